// File: angle_if.sv
// Carrier between the register logic and the angle former
`timescale 1ns/1ps
interface angle_if;
    import tilt_cal_pkg::*;
    logic signed [15:0] raw_half;
    logic [15:0] raw_full;
    logic flip;
    logic signed [15:0] corr;
    logic [15:0] fact;
    logic [15:0] ulim;
    wide_t turned;
    wide_t turned_full;
    logic signed [15:0] angle;
    logic [15:0] full;
    logic f_hi;
    logic f_lo;
    logic u_hi;
    logic u_lo;

    modport former (
        input raw_half, raw_full, flip, corr, fact, ulim,
        output turned, turned_full, angle, full, f_hi, f_lo, u_hi, u_lo
    );
    modport user (
        output raw_half, raw_full, flip, corr, fact, ulim,
        input turned, turned_full, angle, full, f_hi, f_lo, u_hi, u_lo
    );
endinterface

// File: test_tilt_axis_offset_calibration.sv
// Self-checking bench for the tilt axis offset calibration
`timescale 1ns/1ps
module test_tilt_axis_offset_calibration;
    import tilt_cal_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0, req_write = 1'b0, slow = 1'b0, nvm_valid = 1'b0;
    logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, raw_full = 16'h0000;
    logic signed [15:0] raw_half = 16'sh0000, nvm_corr = 16'sh0000;
    logic [15:0] fact_deg = 16'h003c, nvm_flip = 16'h0001, nvm_ulim = 16'h0000;
    logic reply_done, req_ready, rsp_valid, rsp_exc, nvm_store, s_rsp_valid;
    logic [7:0] rsp_code, s_rsp_code, got_c, s_got_c;
    logic [15:0] rsp_data, full_angle, status_word, nvm_wflip, nvm_wulim, s_full, s_status, got_d, got_wu, got_wf;
    logic signed [15:0] axis_angle, nvm_wcorr, s_angle, got_wc, corr, p;
    logic got_v, got_st, inv, got_e;
    logic [31:0] seed = 32'h2ae734bf;
    int errors = 0;
    int total_checks = 0;

    // Clock at 100 ns period
    always #50 clk = ~clk;

    // Dual axis device
    tilt_axis_offset_calibration #(.DUAL_AXIS(1'b1)) dut_u (.clk(clk), .rst_b(rst_b),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .reply_done(reply_done), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_exc(rsp_exc),
        .rsp_code(rsp_code), .rsp_data(rsp_data), .raw_half(raw_half), .raw_full(raw_full),
        .fact_deg(fact_deg), .axis_angle(axis_angle), .full_angle(full_angle), .status_word(status_word),
        .nvm_valid(nvm_valid), .nvm_corr(nvm_corr), .nvm_flip(nvm_flip), .nvm_ulim(nvm_ulim),
        .nvm_store(nvm_store), .nvm_wcorr(nvm_wcorr), .nvm_wflip(nvm_wflip), .nvm_wulim(nvm_wulim));

    // Single axis device on the same requests
    tilt_axis_offset_calibration #(.DUAL_AXIS(1'b0)) sa_u (.clk(clk), .rst_b(rst_b),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .reply_done(reply_done), .req_ready(), .rsp_valid(s_rsp_valid), .rsp_exc(),
        .rsp_code(s_rsp_code), .rsp_data(), .raw_half(raw_half), .raw_full(raw_full),
        .fact_deg(fact_deg), .axis_angle(s_angle), .full_angle(s_full), .status_word(s_status),
        .nvm_valid(nvm_valid), .nvm_corr(nvm_corr), .nvm_flip(nvm_flip), .nvm_ulim(nvm_ulim),
        .nvm_store(), .nvm_wcorr(), .nvm_wflip(), .nvm_wulim());

    // Reply frame pacing
    tilt_reply_model reply_u (.clk(clk), .rst_b(rst_b), .rsp_valid(rsp_valid), .slow(slow),
        .reply_done(reply_done));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction

    // Expected dual axis angle: inversion, offset, factory clamp first, user clamp only inside it
    function automatic logic [15:0] exp_angle(input logic signed [15:0] raw, input logic iv,
                                              input logic signed [15:0] c, input logic [15:0] ul);
        int a;
        int f;
        int u;
        a = int'(raw);
        if (iv) begin
            a = -a;
        end
        a = a + int'(c);
        f = int'(fact_deg) * 100;
        u = int'(ul) * 100;
        if (a > f) begin
            a = f;
        end else if (a < -f) begin
            a = -f;
        end else if (a > u) begin
            a = u;
        end else if (a < -u) begin
            a = -u;
        end
        return a[15:0];
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        if (errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One register request, answer captured just after the clock edge that takes it
    task automatic req(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        tick(1);
        req_valid = 1'b0;
        got_v = rsp_valid;
        got_c = rsp_code;
        got_d = rsp_data;
        s_got_c = s_rsp_code;
        got_st = nvm_store;
        got_wc = nvm_wcorr;
        got_wu = nvm_wulim;
        got_wf = nvm_wflip;
        got_e = rsp_exc;
        check("rsp_valid", {15'h0000, got_v}, 16'h0001);
    endtask

    task automatic rd(input string name, input logic [15:0] a, input logic [15:0] exp);
        req(1'b0, a, 16'h0000);
        check(name, got_d, exp);
    endtask

    task automatic wr(input string name, input logic [15:0] a, input logic [15:0] d, input logic [7:0] code);
        req(1'b1, a, d);
        check(name, {8'h00, got_c}, {8'h00, code});
        check("rsp_exc", {15'h0000, got_e}, {15'h0000, code != EXC_NONE});
    endtask

    // Wait for the reply frame to finish, then for the offset to reach the angle
    task automatic settle;
        int n;
        n = 0;
        while (reply_done !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
        if (n >= 60) errors++;
        tick(2);
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        check("req_ready", {15'h0000, req_ready}, 16'h0001);
    endtask

    // Hang guard
    initial begin
        #2000000;
        errors++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        tick(12);
        rst_b = 1'b1;
        wait_ready();
        rd("flip", A_FLIP, FLIP_OFF);
        rd("corr", A_CORR, 16'h0000);
        rd("ulim", A_ULIM, fact_deg);
        rd("preset", A_PRESET, 16'h0000);
        wr("flip_bad", A_FLIP, 16'h0003, EXC_VALUE);
        wr("angle_ro", A_ANGLE, 16'h0000, EXC_ADDR);
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            raw_half = {{6{seed[9]}}, seed[9:0]};
            inv = seed[16];
            wr("flip", A_FLIP, inv ? FLIP_ON : FLIP_OFF, EXC_NONE);
            tick(3);
            check("angle", axis_angle, exp_angle(raw_half, inv, 16'sh0000, fact_deg));
        end
        wr("flip", A_FLIP, FLIP_ON, EXC_NONE);
        corr = 16'sh0000;
        slow = 1'b1;
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            raw_half = {{6{seed[9]}}, seed[9:0]};
            p = {{6{seed[25]}}, seed[25:16]};
            tick(3);
            wr("preset", A_PRESET, p, EXC_NONE);
            rd("corr_pending", A_CORR, corr);
            settle();
            corr = p + raw_half;
            rd("corr", A_CORR, corr);
            check("angle", axis_angle, p);
        end
        slow = 1'b0;
        wr("zero_bad", A_ZERO, 16'h1234, EXC_VALUE);
        wr("zero", A_ZERO, ZERO_CODE, EXC_NONE);
        settle();
        check("angle_zero", axis_angle, 16'h0000);
        corr = raw_half;
        wr("corr_hi", A_CORR, 16'h0bb9, EXC_VALUE);
        wr("corr_lo", A_CORR, 16'hf447, EXC_VALUE);
        settle();
        rd("corr_kept", A_CORR, corr);
        wr("corr_edge", A_CORR, 16'h0bb8, EXC_NONE);
        settle();
        rd("corr", A_CORR, 16'h0bb8);
        check("angle", axis_angle, exp_angle(raw_half, 1'b1, 16'sh0bb8, fact_deg));
        wr("reload", A_RELOAD, 16'h0000, EXC_NONE);
        rd("ulim", A_ULIM, fact_deg);
        rd("flip", A_FLIP, FLIP_OFF);
        wr("ulim_0", A_ULIM, 16'h0000, EXC_VALUE);
        wr("ulim_big", A_ULIM, 16'h003d, EXC_VALUE);
        wr("ulim", A_ULIM, 16'h0014, EXC_NONE);
        raw_half = 16'sh01f4;
        tick(3);
        wr("preset_far", A_PRESET, 16'h0640, EXC_VALUE);
        settle();
        rd("corr_kept", A_CORR, 16'h0000);
        wr("preset", A_PRESET, 16'h0578, EXC_NONE);
        settle();
        rd("corr", A_CORR, 16'h0384);
        raw_half = 16'sh1b58;
        tick(3);
        check("angle_clamp", axis_angle, exp_angle(raw_half, 1'b0, 16'sh0384, 16'h0014));
        check("f_hi", {15'h0000, status_word[ST_F_HI]}, 16'h0001);
        raw_half = 16'shdcd8;
        tick(3);
        check("f_lo", {15'h0000, status_word[ST_F_LO]}, 16'h0001);
        rd("status", A_STATUS, 16'h0002);
        raw_half = 16'sh0bb8;
        tick(3);
        check("angle_user", axis_angle, exp_angle(raw_half, 1'b0, 16'sh0384, 16'h0014));
        check("u_hi", {15'h0000, status_word[ST_U_HI]}, 16'h0001);
        check("s_user_flags", {14'h0000, s_status[ST_U_LO:ST_U_HI]}, 16'h0000);
        wr("store", A_STORE, 16'h0000, EXC_NONE);
        check("nvm_store", {15'h0000, got_st}, 16'h0001);
        check("nvm_wcorr", got_wc, 16'h0384);
        check("nvm_wulim", got_wu, 16'h0014);
        check("nvm_wflip", got_wf, FLIP_OFF);
        nvm_valid = 1'b1;
        nvm_corr = 16'sh0384;
        nvm_flip = FLIP_ON;
        nvm_ulim = 16'h0014;
        rst_b = 1'b0;
        tick(2);
        rst_b = 1'b1;
        wait_ready();
        rd("corr_boot", A_CORR, 16'h0384);
        rd("flip_boot", A_FLIP, FLIP_ON);
        rd("ulim_boot", A_ULIM, 16'h0014);
        wr("reload", A_RELOAD, 16'h0000, EXC_NONE);
        raw_half = 16'sh0000;
        raw_full = 16'h1388;
        tick(3);
        wr("preset", A_PRESET, 16'h0064, EXC_NONE);
        settle();
        check("s_full", s_full, 16'h0064);
        check("s_half", s_angle, 16'hecdc);
        check("full", full_angle, 16'h13ec);
        wr("corr_sa_hi", A_CORR, 16'h4651, EXC_VALUE);
        check("s_code_hi", {8'h00, s_got_c}, {8'h00, EXC_VALUE});
        wr("corr_sa_lo", A_CORR, 16'hb9b0, EXC_VALUE);
        check("s_code_lo", {8'h00, s_got_c}, {8'h00, EXC_NONE});
        report_and_stop();
    end
endmodule

// File: tilt_angle_former.sv
// Inversion, correction and range clamp of the axis angle, wrap of the full turn reading
`timescale 1ns/1ps
module tilt_angle_former
    import tilt_cal_pkg::*;
#(
    parameter bit DUAL = 1'b1
) (
    // Angle path
    angle_if.former io
);
    // ------------------------------------------------------------
    // Sign inversion ahead of the correction
    // ------------------------------------------------------------
    wide_t raw_w;
    wide_t full_w;
    wide_t sum;
    wide_t fsum;
    wide_t f_lim;
    wide_t u_lim;
    assign raw_w = wide_t'(io.raw_half);
    assign full_w = wide_t'({8'h00, io.raw_full});
    assign io.turned = io.flip ? -raw_w : raw_w;
    // Full turn: inversion turns the rotation direction round
    assign io.turned_full = (io.flip && full_w != '0) ? FULL_TURN - full_w : full_w;
    assign sum = io.turned + wide_t'(io.corr);
    assign fsum = io.turned_full + wide_t'(io.corr);
    assign f_lim = wide_t'({8'h00, io.fact}) * CENT_PER_DEG;
    assign u_lim = wide_t'({8'h00, io.ulim}) * CENT_PER_DEG;

    // Factory limit first, user limit second
    always_comb begin
        io.f_hi = 1'b0;
        io.f_lo = 1'b0;
        io.u_hi = 1'b0;
        io.u_lo = 1'b0;
        io.angle = sum[15:0];
        if (sum > f_lim) begin
            io.angle = f_lim[15:0];
            io.f_hi = 1'b1;
        end else if (sum < -f_lim) begin
            io.angle = 16'(-f_lim);
            io.f_lo = 1'b1;
        end else if (sum > u_lim) begin
            io.angle = u_lim[15:0];
            io.u_hi = DUAL;
        end else if (sum < -u_lim) begin
            io.angle = 16'(-u_lim);
            io.u_lo = DUAL;
        end
    end

    // Full turn reading wraps into one turn
    always_comb begin
        io.full = fsum[15:0];
        if (fsum < 0) begin
            io.full = 16'(fsum + FULL_TURN);
        end else if (fsum >= FULL_TURN) begin
            io.full = 16'(fsum - FULL_TURN);
        end
    end
endmodule

// File: tilt_axis_offset_calibration.sv
// Register side of the tilt axis offset calibration
`timescale 1ns/1ps
module tilt_axis_offset_calibration
    import tilt_cal_pkg::*;
#(
    parameter bit DUAL_AXIS = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register requests from the frame decoder
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic reply_done,
    // Answer to the frame encoder
    output logic req_ready,
    output logic rsp_valid,
    output logic rsp_exc,
    output logic [7:0] rsp_code,
    output logic [15:0] rsp_data,
    // Sensor front end
    input wire logic signed [15:0] raw_half,
    input wire logic [15:0] raw_full,
    input wire logic [15:0] fact_deg,
    // Readings
    output logic signed [15:0] axis_angle,
    output logic [15:0] full_angle,
    output logic [15:0] status_word,
    // Non-volatile store
    input wire logic nvm_valid,
    input wire logic signed [15:0] nvm_corr,
    input wire logic [15:0] nvm_flip,
    input wire logic [15:0] nvm_ulim,
    output logic nvm_store,
    output logic signed [15:0] nvm_wcorr,
    output logic [15:0] nvm_wflip,
    output logic [15:0] nvm_wulim
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    phase_e ph_q;
    logic signed [15:0] corr_q;
    logic signed [15:0] pend_q;
    logic pend_v_q;
    logic [15:0] flip_q;
    logic [15:0] ulim_q;
    logic rsp_v_q;
    logic rsp_e_q;
    logic [7:0] rsp_c_q;
    logic [15:0] rsp_d_q;
    logic signed [15:0] ang_q;
    logic [15:0] full_q;
    logic [15:0] stat_q;
    logic [15:0] stat_d;
    logic store_q;

    function automatic logic is_addr(input logic [15:0] a, input logic [15:0] b);
        return a == b;
    endfunction

    // ------------------------------------------------------------
    // Angle former
    // ------------------------------------------------------------
    angle_if ai();
    assign ai.raw_half = raw_half;
    assign ai.raw_full = raw_full;
    assign ai.flip = (flip_q == FLIP_ON);
    assign ai.corr = corr_q;
    assign ai.fact = fact_deg;
    assign ai.ulim = ulim_q;

    tilt_angle_former #(.DUAL(DUAL_AXIS)) u_former (.io(ai.former));

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    wire run = (ph_q == PH_RUN);
    wire acc = req_valid && run;
    wire wr = acc && req_write;
    wire rd = acc && !req_write;
    wire w_zero = wr && is_addr(req_addr, A_ZERO);
    wire w_pre = wr && is_addr(req_addr, A_PRESET);
    wire w_corr = wr && is_addr(req_addr, A_CORR);
    wire w_flip = wr && is_addr(req_addr, A_FLIP);
    wire w_ulim = wr && is_addr(req_addr, A_ULIM);
    wire w_store = wr && is_addr(req_addr, A_STORE);
    wire w_rel = wr && is_addr(req_addr, A_RELOAD);
    wire w_off = w_zero || w_pre || w_corr;
    wire known_w = w_off || w_flip || w_ulim || w_store || w_rel;
    wire known_r = is_addr(req_addr, A_ANGLE) || is_addr(req_addr, A_HALF)
        || is_addr(req_addr, A_FULL) || is_addr(req_addr, A_STATUS)
        || is_addr(req_addr, A_ZERO) || is_addr(req_addr, A_PRESET)
        || is_addr(req_addr, A_CORR) || is_addr(req_addr, A_FLIP)
        || is_addr(req_addr, A_ULIM);

    // ------------------------------------------------------------
    // Offset computation and range checks
    // ------------------------------------------------------------
    wide_t target;
    wide_t turned;
    wide_t calc;
    wide_t cand;
    wide_t half_lim;
    assign target = w_zero ? wide_t'(0) : wide_t'($signed(req_wdata));
    assign turned = DUAL_AXIS ? ai.turned : ai.turned_full;
    assign calc = target - turned;
    assign cand = w_corr ? wide_t'($signed(req_wdata)) : calc;
    assign half_lim = wide_t'({8'h00, ulim_q}) * CENT_PER_DEG;
    wire corr_ok = DUAL_AXIS ? (2 * cand <= half_lim && 2 * cand >= -half_lim)
                             : (cand <= HALF_TURN && cand >= -HALF_TURN);
    wire code_ok = !w_zero || req_wdata == ZERO_CODE;
    wire flip_ok = req_wdata == FLIP_OFF || req_wdata == FLIP_ON;
    wire [15:0] ulim_max = DUAL_AXIS ? fact_deg : ULIM_MAX_SA;
    wire ulim_ok = req_wdata >= ULIM_MIN && req_wdata <= ulim_max;
    wire bad_val = (w_off && !(corr_ok && code_ok)) || (w_flip && !flip_ok)
        || (w_ulim && !ulim_ok);
    wire bad_addr = (wr && !known_w) || (rd && !known_r);
    wire take = w_off && !bad_val;

    // Read data; command registers read as zero
    wire [15:0] rd_data =
        is_addr(req_addr, A_ANGLE) ? ang_q :
        is_addr(req_addr, A_HALF) ? ang_q :
        is_addr(req_addr, A_FULL) ? full_q :
        is_addr(req_addr, A_STATUS) ? stat_q :
        is_addr(req_addr, A_CORR) ? corr_q :
        is_addr(req_addr, A_FLIP) ? flip_q :
        is_addr(req_addr, A_ULIM) ? ulim_q : 16'h0000;

    // Status word from the former's flags
    always_comb begin
        stat_d = '0;
        stat_d[ST_F_HI] = ai.f_hi;
        stat_d[ST_F_LO] = ai.f_lo;
        stat_d[ST_U_HI] = ai.u_hi;
        stat_d[ST_U_LO] = ai.u_lo;
    end

    // ------------------------------------------------------------
    // Boot phase: one cycle to pick up stored settings
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ph_q <= PH_BOOT;
        end else begin
            ph_q <= PH_RUN;
        end
    end

    // Pending offset waits for the reply frame
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pend_v_q <= 1'b0;
            pend_q <= CORR_RST;
        end else if (take) begin
            pend_v_q <= 1'b1;
            pend_q <= cand[15:0];
        end else if (reply_done || w_rel) begin
            pend_v_q <= 1'b0;
        end
    end

    // Working offset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            corr_q <= CORR_RST;
        end else if (!run) begin
            corr_q <= nvm_valid ? nvm_corr : CORR_RST;
        end else if (w_rel) begin
            corr_q <= CORR_RST;
        end else if (reply_done && pend_v_q) begin
            corr_q <= pend_q;
        end
    end

    // Inversion setting, effective at once
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flip_q <= FLIP_OFF;
        end else if (!run) begin
            flip_q <= (nvm_valid && nvm_flip == FLIP_ON) ? FLIP_ON : FLIP_OFF;
        end else if (w_rel) begin
            flip_q <= FLIP_OFF;
        end else if (w_flip && flip_ok) begin
            flip_q <= req_wdata;
        end
    end

    // User range; falls back to the factory range
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ulim_q <= ULIM_MIN;
        end else if (!run) begin
            ulim_q <= (nvm_valid && nvm_ulim != '0) ? nvm_ulim : fact_deg;
        end else if (w_rel) begin
            ulim_q <= fact_deg;
        end else if (w_ulim && ulim_ok) begin
            ulim_q <= req_wdata;
        end
    end

    // Answer, readings and store strobe
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rsp_v_q <= 1'b0;
            rsp_e_q <= 1'b0;
            rsp_c_q <= EXC_NONE;
            rsp_d_q <= '0;
            ang_q <= '0;
            full_q <= '0;
            stat_q <= '0;
            store_q <= 1'b0;
        end else begin
            rsp_v_q <= acc;
            rsp_e_q <= bad_val || bad_addr;
            rsp_c_q <= bad_addr ? EXC_ADDR : (bad_val ? EXC_VALUE : EXC_NONE);
            rsp_d_q <= rd ? rd_data : req_wdata;
            ang_q <= ai.angle;
            full_q <= ai.full;
            stat_q <= stat_d;
            store_q <= w_store;
        end
    end

    assign req_ready = run;
    assign rsp_valid = rsp_v_q;
    assign rsp_exc = rsp_e_q;
    assign rsp_code = rsp_c_q;
    assign rsp_data = rsp_d_q;
    assign axis_angle = ang_q;
    assign full_angle = full_q;
    assign status_word = stat_q;
    assign nvm_store = store_q;
    assign nvm_wcorr = corr_q;
    assign nvm_wflip = flip_q;
    assign nvm_wulim = ulim_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    preset_reads_zero_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        rd && is_addr(req_addr, A_PRESET) |=> rsp_valid && rsp_data == 16'h0000)
        else $error("preset read not zero");

    offset_waits_reply_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        $past(run) && $changed(corr_q) |-> $past(reply_done) || $past(w_rel))
        else $error("offset changed before reply sent");

    pend_single_range_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        !DUAL_AXIS && pend_v_q |-> wide_t'(pend_q) <= HALF_TURN && wide_t'(pend_q) >= -HALF_TURN)
        else $error("single axis offset out of range");

    pend_dual_range_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        DUAL_AXIS && pend_v_q |-> 2 * wide_t'(pend_q) <= wide_t'({8'h00, ulim_q}) * CENT_PER_DEG
        && 2 * wide_t'(pend_q) >= -(wide_t'({8'h00, ulim_q}) * CENT_PER_DEG))
        else $error("dual axis offset beyond half range");

    refuse_keeps_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        rsp_valid && rsp_code == EXC_VALUE |-> $stable(pend_q) && $stable(corr_q))
        else $error("refused offset altered state");

    bad_offset_exc_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        w_corr && !DUAL_AXIS && $signed(req_wdata) > $signed(HALF_TURN[15:0])
        |=> rsp_valid && rsp_exc && rsp_code == EXC_VALUE)
        else $error("out of range offset accepted");

    preset_math_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        take && w_pre |=> pend_v_q && wide_t'(pend_q) + $past(turned) == wide_t'($signed($past(req_wdata))))
        else $error("preset offset miscomputed");

    flip_negates_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        run && flip_q == FLIP_ON && corr_q == 16'sh0000 && !ai.f_hi && !ai.f_lo && !ai.u_hi && !ai.u_lo
        |=> axis_angle == -$past(raw_half))
        else $error("inversion did not negate angle");

    clamp_high_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        status_word[ST_F_HI] |-> wide_t'(axis_angle) == $past(wide_t'({8'h00, fact_deg}) * CENT_PER_DEG))
        else $error("factory clamp value wrong");

    reload_range_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        w_rel |=> ulim_q == $past(fact_deg))
        else $error("reload did not restore factory range");
endmodule

// File: tilt_cal_pkg.sv
// Constants, register map and types for the tilt axis calibration block
package tilt_cal_pkg;
    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] A_ANGLE = 16'h0001;
    localparam logic [15:0] A_HALF = 16'h0003;
    localparam logic [15:0] A_FULL = 16'h0004;
    localparam logic [15:0] A_STATUS = 16'h0006;
    localparam logic [15:0] A_ZERO = 16'h0014;
    localparam logic [15:0] A_PRESET = 16'h0015;
    localparam logic [15:0] A_CORR = 16'h0016;
    localparam logic [15:0] A_FLIP = 16'h0017;
    localparam logic [15:0] A_ULIM = 16'h0018;
    localparam logic [15:0] A_STORE = 16'h0032;
    localparam logic [15:0] A_RELOAD = 16'h0033;

    // ------------------------------------------------------------
    // Field values and codes
    // ------------------------------------------------------------
    localparam logic [15:0] ZERO_CODE = 16'h5a58;
    localparam logic [15:0] FLIP_OFF = 16'h0001;
    localparam logic [15:0] FLIP_ON = 16'h0002;
    localparam logic [15:0] ULIM_MIN = 16'h0001;
    localparam logic [15:0] ULIM_MAX_SA = 16'h00b4;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic signed [15:0] CORR_RST = 16'sh0000;

    // Status word bit positions
    localparam int ST_F_HI = 0;
    localparam int ST_F_LO = 1;
    localparam int ST_U_HI = 2;
    localparam int ST_U_LO = 3;

    // ------------------------------------------------------------
    // Arithmetic in hundredths of a degree
    // ------------------------------------------------------------
    typedef logic signed [23:0] wide_t;
    localparam wide_t CENT_PER_DEG = 24'sh000064;
    localparam wide_t HALF_TURN = 24'sh004650;
    localparam wide_t FULL_TURN = 24'sh008ca0;

    typedef enum logic {PH_BOOT, PH_RUN} phase_e;
endpackage

// File: tilt_reply_model.sv
// Reply frame timing model of the bus master side
`timescale 1ns/1ps
module tilt_reply_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Reply start and pace
    input wire logic rsp_valid,
    input wire logic slow,
    // Reply frame fully sent
    output logic reply_done
);
    logic [5:0] left_q;

    // Count out the reply frame, restart on every new reply
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            left_q <= 6'h00;
            reply_done <= 1'b0;
        end else begin
            reply_done <= (left_q == 6'h01);
            if (rsp_valid) begin
                left_q <= slow ? 6'h14 : 6'h02;
            end else if (left_q != 6'h00) begin
                left_q <= left_q - 6'h01;
            end
        end
    end
endmodule
